// *** crb_rx_filter.sv ***
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "crb_defines.svh"
//Behaviour
//RULE1: Full flag set on store into buffer 0; software clear reopens it.
//RULE2: Mode 11 takes everything incl. errors; mode 00 takes all valid.
//RULE3: Mode 10 takes valid extended only; mode 01 valid standard only.
//RULE4: Double-buffer enable set sends overflow of buffer 0 into buffer 1.
//RULE5: Jump offset bit reads as copy of double-buffer enable, not writable.
//RULE6: Filter hit bit tells which filter admitted buffer 0; read-only.
//RULE7: Each filter has writable extended id high and low match bytes.
//RULE8: Mask high byte masks standard bits 10:3 or extended bits 28:21.
//RULE9: Bit matches when mask zero or bits equal; all bits must match.
module crb_rx_filter
   import crb_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        msg_valid_i,
   input  wire logic [28:0] msg_ident_i,
   input  wire logic        msg_ext_i,
   input  wire logic        msg_rtr_i,
   input  wire logic        msg_error_i,
   output logic             msg_stored_o,
   output logic             buf0_full_o,
   output logic             buf1_full_o
);
   localparam int MW = `CRB_MEM_DEPTH * 8;

   // Byte pick from the flat filter array
   function automatic logic [7:0] pick(input logic [MW-1:0] b,
                                       input logic [3:0]    i);
      pick = b[32'(i)*8 +: 8];
   endfunction

   // Masked byte compare: zero mask bit means don't care
   function automatic logic byte_ok(input logic [7:0] rx,
                                    input logic [7:0] flt,
                                    input logic [7:0] msk);
      byte_ok = &(~msk | ~(rx ^ flt));
   endfunction

   logic [MW-1:0] mem_bytes;
   logic [7:0]    mem_rdata;
   crb_mode_t     mode_reg;
   logic          dben_reg, full0_reg, rtr0_reg, hit0_reg;
   logic          full1_reg, rtr1_reg, hit1_reg, ovf1_reg;
   logic [28:0]   id0_reg, id1_reg;
   logic [31:0]   prdata_reg, rd_next;
   logic          is_mem_reg;

   // Bus phase and address decode
   wire        setup    = psel_i & ~penable_i;
   wire        access   = psel_i & penable_i;
   wire        wr       = access & pwrite_i;
   wire [7:0]  mem_off  = paddr_i - `CRB_OFF_MEM_FIRST;
   wire [3:0]  mem_idx  = mem_off[5:2];
   wire        hit_ctrl = paddr_i == `CRB_OFF_CTRL;
   wire        hit_b1   = paddr_i == `CRB_OFF_B1_STAT;
   wire        hit_id0  = paddr_i == `CRB_OFF_B0_IDENT;
   wire        hit_id1  = paddr_i == `CRB_OFF_B1_IDENT;
   wire        hit_mem  = paddr_i >= `CRB_OFF_MEM_FIRST &&
                          paddr_i <= `CRB_OFF_MEM_LAST &&
                          paddr_i[1:0] == 2'h0;
   wire        mapped   = hit_ctrl | hit_b1 | hit_id0 | hit_id1 | hit_mem;

   // Zero wait states; unmapped addresses answer with an error
   assign pready_o  = 1'b1;
   assign pslverr_o = access & ~mapped;

   // RULE7: filter match bytes
   crb_regmem #(.DEPTH(`CRB_MEM_DEPTH), .AW(4)) u_mem (
      .sys_clk_i (sys_clk_i),
      .we_i      (wr & hit_mem),
      .waddr_i   (mem_idx),
      .wdata_i   (pwdata_i[7:0]),
      .raddr_i   (mem_idx),
      .rdata_o   (mem_rdata),
      .bytes_o   (mem_bytes)
   );

   // Filter and mask fields
   wire [7:0] f0_sidh = pick(mem_bytes, `CRB_IDX_F0_SIDH);
   wire [7:0] f0_eidh = pick(mem_bytes, `CRB_IDX_F0_EIDH);
   wire [7:0] f0_eidl = pick(mem_bytes, `CRB_IDX_F0_EIDL);
   wire [7:0] f1_sidh = pick(mem_bytes, `CRB_IDX_F1_SIDH);
   wire [7:0] f1_eidh = pick(mem_bytes, `CRB_IDX_F1_EIDH);
   wire [7:0] f1_eidl = pick(mem_bytes, `CRB_IDX_F1_EIDL);
   wire [7:0] m0_sidh = pick(mem_bytes, `CRB_IDX_M0_SIDH);
   wire [7:0] m0_eidh = pick(mem_bytes, `CRB_IDX_M0_EIDH);
   wire [7:0] m0_eidl = pick(mem_bytes, `CRB_IDX_M0_EIDL);

   // RULE8: mask byte placement
   wire [7:0] rx_top  = msg_ext_i ? msg_ident_i[28:21] : msg_ident_i[10:3];
   // RULE9: all masked bytes must match; low bytes only for extended
   wire hit_f0 = byte_ok(rx_top, f0_sidh, m0_sidh) & (~msg_ext_i |
                 (byte_ok(msg_ident_i[15:8], f0_eidh, m0_eidh) &
                  byte_ok(msg_ident_i[7:0], f0_eidl, m0_eidl)));
   wire hit_f1 = byte_ok(rx_top, f1_sidh, m0_sidh) & (~msg_ext_i |
                 (byte_ok(msg_ident_i[15:8], f1_eidh, m0_eidh) &
                  byte_ok(msg_ident_i[7:0], f1_eidl, m0_eidl)));
   wire which  = ~hit_f0 & hit_f1;  // Filter zero wins a double hit

   // RULE2 RULE3: acceptance by mode and frame format
   logic fmt_ok;
   always_comb begin
      unique case (mode_reg)
         CRB_MODE_ALL_VALID:  fmt_ok = ~msg_error_i;
         CRB_MODE_STD_ONLY:   fmt_ok = ~msg_error_i & ~msg_ext_i;
         CRB_MODE_EXT_ONLY:   fmt_ok = ~msg_error_i & msg_ext_i;
         CRB_MODE_EVERYTHING: fmt_ok = 1'b1;
      endcase
   end
   wire everything = mode_reg == CRB_MODE_EVERYTHING;
   wire accept     = msg_valid_i & fmt_ok & (everything | hit_f0 | hit_f1);

   // RULE4: overflow routing into buffer 1
   wire to_b0 = accept & ~full0_reg;
   wire to_b1 = accept & full0_reg & dben_reg & ~full1_reg;
   wire drop  = accept & ~to_b0 & ~to_b1;
   assign msg_stored_o = to_b0 | to_b1;

   // Software clears by writing zero to a full or overflow flag
   wire clr0 = wr & hit_ctrl & ~pwdata_i[`CRB_BIT_FULL];
   wire clr1 = wr & hit_b1 & ~pwdata_i[`CRB_BIT_FULL];
   wire clro = wr & hit_b1 & ~pwdata_i[`CRB_BIT_OVF];

   // Writable control fields
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_reg <= crb_mode_t'(`CRB_RST_MODE);
         dben_reg <= `CRB_RST_BIT;
      end else if (wr & hit_ctrl) begin
         mode_reg <= crb_mode_t'(pwdata_i[`CRB_BIT_MODE_HI:`CRB_BIT_MODE_LO]);
         dben_reg <= pwdata_i[`CRB_BIT_DBEN];
      end
   end

   // RULE1: full flags, set wins over clear
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         full0_reg <= `CRB_RST_BIT;
         full1_reg <= `CRB_RST_BIT;
         ovf1_reg  <= `CRB_RST_BIT;
      end else begin
         full0_reg <= to_b0 | (full0_reg & ~clr0);
         full1_reg <= to_b1 | (full1_reg & ~clr1);
         ovf1_reg  <= drop | (ovf1_reg & ~clro);
      end
   end

   // RULE6: hit and remote bits follow the stored message only
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {hit0_reg, rtr0_reg, id0_reg} <= '0;
         {hit1_reg, rtr1_reg, id1_reg} <= '0;
      end else begin
         if (to_b0) {hit0_reg, rtr0_reg, id0_reg} <=
                       {which, msg_rtr_i, msg_ident_i};
         if (to_b1) {hit1_reg, rtr1_reg, id1_reg} <=
                       {which, msg_rtr_i, msg_ident_i};
      end
   end

   // RULE5: jump offset bit mirrors the double-buffer enable
   wire [7:0] ctrl_rd = {full0_reg, mode_reg, 1'b0, rtr0_reg,
                         dben_reg, dben_reg, hit0_reg};
   wire [7:0] b1_rd   = {full1_reg, ovf1_reg, 2'h0, rtr1_reg,
                         2'h0, hit1_reg};
   assign rd_next = hit_ctrl ? {24'h0, ctrl_rd} :
                    hit_b1   ? {24'h0, b1_rd} :
                    hit_id0  ? {3'h0, id0_reg} :
                    hit_id1  ? {3'h0, id1_reg} : 32'h0;

   // Read data captured in setup so it is stable through access
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_reg <= 32'h0;
         is_mem_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= rd_next;
         is_mem_reg <= hit_mem;
      end
   end
   assign prdata_o    = is_mem_reg ? {24'h0, mem_rdata} : prdata_reg;
   assign buf0_full_o = full0_reg;
   assign buf1_full_o = full1_reg;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   // Store then flag, cleared only by software
   sequence s_store0;
      to_b0 ##1 full0_reg;
   endsequence
   full_set_a: assert property (to_b0 |-> s_store0) // RULE1
      else $error("buffer 0 full flag not set after store");
   full_clr_a: assert property (full0_reg && clr0 |=> !full0_reg) // RULE1
      else $error("buffer 0 full flag not cleared");
   mode_all_a: assert property ( // RULE2
      msg_valid_i && everything && !full0_reg |-> to_b0)
      else $error("everything mode dropped a message");
   mode_fmt_a: assert property ( // RULE3
      msg_stored_o && mode_reg == CRB_MODE_EXT_ONLY |->
      msg_ext_i && !msg_error_i)
      else $error("extended-only mode took a wrong frame");
   sequence s_no_b1;
      !to_b1 ##1 $stable(id1_reg);
   endsequence
   no_dbuf_a: assert property ( // RULE4
      accept && full0_reg && !dben_reg |-> s_no_b1)
      else $error("overflow reached buffer 1 while disabled");
   jump_copy_a: assert property ( // RULE5
      access && !pwrite_i && hit_ctrl |->
      prdata_o[`CRB_BIT_JOFF] == dben_reg &&
      prdata_o[`CRB_BIT_DBEN] == dben_reg)
      else $error("jump offset differs from double-buffer enable");
   hit_rec_a: assert property ( // RULE6
      to_b0 |=> hit0_reg == $past(which))
      else $error("filter hit bit wrong");
   hit_hold_a: assert property ( // RULE6
      !to_b0 |=> $stable(hit0_reg))
      else $error("filter hit bit changed without a store");
   filt_wr_a: assert property ( // RULE7
      wr && hit_mem |=> pick(mem_bytes, $past(mem_idx)) ==
                        $past(pwdata_i[7:0]))
      else $error("filter byte not written");
   mask_std_a: assert property ( // RULE8
      !msg_ext_i && ((msg_ident_i[10:3] ^ f0_sidh) & m0_sidh) != 8'h00
      |-> !hit_f0)
      else $error("masked standard bit mismatch ignored");
   mask_zero_a: assert property ( // RULE9
      msg_valid_i && !msg_error_i && mode_reg == CRB_MODE_ALL_VALID &&
      m0_sidh == 8'h00 && m0_eidh == 8'h00 && m0_eidl == 8'h00 |-> accept)
      else $error("zero mask did not accept");
endmodule

// *** crb_defines.svh ***
`ifndef CRB_DEFINES_SVH
`define CRB_DEFINES_SVH

// Register byte offsets on the bus
`define CRB_OFF_CTRL      8'h00
`define CRB_OFF_MEM_FIRST 8'h04
`define CRB_OFF_MEM_LAST  8'h24
`define CRB_OFF_B1_STAT   8'h28
`define CRB_OFF_B0_IDENT  8'h2c
`define CRB_OFF_B1_IDENT  8'h30

// Filter and mask byte slots in the small memory
`define CRB_MEM_DEPTH     9
`define CRB_IDX_F0_SIDH   4'h0
`define CRB_IDX_F0_EIDH   4'h1
`define CRB_IDX_F0_EIDL   4'h2
`define CRB_IDX_F1_SIDH   4'h3
`define CRB_IDX_F1_EIDH   4'h4
`define CRB_IDX_F1_EIDL   4'h5
`define CRB_IDX_M0_SIDH   4'h6
`define CRB_IDX_M0_EIDH   4'h7
`define CRB_IDX_M0_EIDL   4'h8

// Control and buffer 1 status bit positions
`define CRB_BIT_FULL      7
`define CRB_BIT_MODE_HI   6
`define CRB_BIT_MODE_LO   5
`define CRB_BIT_OVF       6
`define CRB_BIT_RTR       3
`define CRB_BIT_DBEN      2
`define CRB_BIT_JOFF      1
`define CRB_BIT_HIT       0

// Reset values
`define CRB_RST_MODE      2'h0
`define CRB_RST_BIT       1'b0

`endif

// *** crb_pkg.sv ***
package crb_pkg;
   // Receive buffer acceptance modes
   typedef enum logic [1:0] {
      CRB_MODE_ALL_VALID = 2'h0,
      CRB_MODE_STD_ONLY  = 2'h1,
      CRB_MODE_EXT_ONLY  = 2'h2,
      CRB_MODE_EVERYTHING = 2'h3
   } crb_mode_t;
endpackage

// *** crb_regmem.sv ***
`timescale 1ns/100ps
module crb_regmem #(
   parameter int DEPTH = 9,
   parameter int AW    = 4
) (
   input  wire logic                 sys_clk_i,
   input  wire logic                 we_i,
   input  wire logic [AW-1:0]        waddr_i,
   input  wire logic [7:0]           wdata_i,
   input  wire logic [AW-1:0]        raddr_i,
   output logic      [7:0]           rdata_o,
   output logic      [DEPTH*8-1:0]   bytes_o
);
   logic [7:0] mem_reg [DEPTH];

   // No reset: filter contents are undefined until software writes them
   always_ff @(posedge sys_clk_i) begin
      if (we_i) begin
         mem_reg[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_reg[raddr_i];
   end

   // Whole array visible at once for the parallel compare
   for (genvar i = 0; i < DEPTH; i++) begin : g_flat
      assign bytes_o[i*8 +: 8] = mem_reg[i];
   end
endmodule

// *** crb_engine_model.sv ***
`timescale 1ns/100ps
// Protocol engine stand-in; idle fields invert so stale data never passes
module crb_engine_model (
   input  wire logic        sys_clk_i,
   input  wire logic        msg_stored_i,
   output logic             msg_valid_o,
   output logic [28:0]      msg_ident_o,
   output logic             msg_ext_o,
   output logic             msg_rtr_o,
   output logic             msg_error_o
);
   initial begin
      msg_valid_o = 1'b0;
      msg_ident_o = '0;
      msg_ext_o = 1'b0;
      msg_rtr_o = 1'b0;
      msg_error_o = 1'b0;
   end
   // One-cycle message pulse after an optional idle gap
   task automatic send(input logic [28:0] id, input logic ext, rtr, err,
                       input int gap, output logic took);
      repeat (gap) @(posedge sys_clk_i);
      msg_valid_o <= 1'b1;
      msg_ident_o <= id;
      msg_ext_o <= ext;
      msg_rtr_o <= rtr;
      msg_error_o <= err;
      @(posedge sys_clk_i);
      took = msg_stored_i;
      msg_valid_o <= 1'b0;
      msg_ident_o <= ~id;
      msg_ext_o <= ~ext;
      msg_rtr_o <= ~rtr;
      msg_error_o <= ~err;
   endtask
endmodule

// *** can_receive_buffer_filters_tb.sv ***
`timescale 1ns/100ps
module can_receive_buffer_filters_tb;
   logic        clk;
   logic        rst_n = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, m_valid, m_ext, m_rtr, m_err, stored;
   logic [28:0] m_id;
   logic        full0, full1;
   int          failures = 0;
   int          check_count = 0;
   int          cyc = 0;
   logic [31:0] seed = 32'h0ad7;
   logic [7:0]  fv [9] = '{8'h80, 8'h5a, 8'h01, 8'h00, 8'ha5, 8'h00,
                           8'h80, 8'h00, 8'h01};

   crb_rx_filter u_crb_rx_filter (.sys_clk_i(clk), .resetn_i(rst_n),
      .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .msg_valid_i(m_valid),
      .msg_ident_i(m_id), .msg_ext_i(m_ext), .msg_rtr_i(m_rtr),
      .msg_error_i(m_err), .msg_stored_o(stored), .buf0_full_o(full0),
      .buf1_full_o(full1));
   crb_engine_model u_crb_engine_model (.sys_clk_i(clk),
      .msg_stored_i(stored), .msg_valid_o(m_valid), .msg_ident_o(m_id),
      .msg_ext_o(m_ext), .msg_rtr_o(m_rtr), .msg_error_o(m_err));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard, far above the several hundred cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, exp, input string what);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // APB transfer held until pready is sampled high
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e;
      apb(a, 1'b1, {24'h0, d}, q, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb(a, 1'b0, 32'h0, q, e);
      chk(q, exp, "read data");
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Masked compare; mask bits at zero always match
   function automatic logic fhit(input int f, input logic [28:0] id,
                                 input logic ext);
      logic [7:0] hi;
      hi = ext ? id[28:21] : id[10:3];
      if (((hi ^ fv[3*f]) & fv[6]) != 8'h0)
         return 1'b0;
      if (!ext)
         return 1'b1;
      return (((id[15:8] ^ fv[3*f+1]) & fv[7]) == 8'h0) &&
             (((id[7:0] ^ fv[3*f+2]) & fv[8]) == 8'h0);
   endfunction
   // Returns {accepted, filter hit bit}
   function automatic logic [1:0] expect_msg(input logic [1:0] md,
      input logic [28:0] id, input logic ext, err);
      logic h0, h1;
      h0 = fhit(0, id, ext);
      h1 = fhit(1, id, ext);
      if (md == 2'h3)
         return {1'b1, h1 & ~h0};
      return {~err & (h0 | h1) & ((md == 2'h0) | (md[1] == ext)), ~h0};
   endfunction

   initial begin
      logic [31:0] q;
      logic        e, t;
      logic [1:0]  x, md;
      logic [7:0]  held = 8'h00;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rdc(8'h00, 32'h0);
      rdc(8'h28, 32'h0);
      for (int k = 0; k < 9; k++)
         wr(8'h04 + 8'(4 * k), fv[k]);
      for (int k = 0; k < 9; k++)
         rdc(8'h04 + 8'(4 * k), {24'h0, fv[k]});
      apb(8'h34, 1'b0, 32'h0, q, e);
      chk({31'h0, e}, 32'h1, "unmapped error");
      $display("test registers done");
      for (int i = 0; i < 48; i++) begin
         seed = lfsr(seed);
         md = 2'(i);
         wr(8'h00, {1'b0, md, 5'h03});
         u_crb_engine_model.send(seed[28:0], seed[29], seed[31],
                                 seed[30] & seed[3], int'(seed[5:4]), t);
         x = expect_msg(md, seed[28:0], seed[29], seed[30] & seed[3]);
         #1;
         chk({31'h0, t}, {31'h0, x[1]}, "stored");
         chk({31'h0, full0}, {31'h0, x[1]}, "buffer 0 full");
         if (x[1]) begin
            // Remote and hit bits stay until the next store
            held = {4'h0, seed[31], 2'h0, x[0]};
            rdc(8'h00, {24'h0, 1'b1, md, 1'b0, seed[31], 2'h0, x[0]});
            if (seed[29])
               rdc(8'h2c, {3'h0, seed[28:0]});
            wr(8'h00, {1'b0, md, 5'h0});
            #1;
            chk({31'h0, full0}, 32'h0, "cleared");
         end
      end
      $display("test acceptance done");
      wr(8'h00, 8'h64);
      rdc(8'h00, 32'h66 | {24'h0, held});
      for (int n = 0; n < 3; n++) begin
         u_crb_engine_model.send(29'h400, 1'b0, 1'b0, 1'b0, n, t);
         chk({31'h0, t}, {31'h0, n != 2}, "overflow store");
      end
      #1;
      chk({30'h0, full1, full0}, 32'h3, "both full");
      apb(8'h28, 1'b0, 32'h0, q, e);
      chk(q & 32'hc0, 32'hc0, "overflow bit");
      wr(8'h28, 8'h00);
      wr(8'h00, 8'h60);
      rdc(8'h00, 32'h60);
      for (int n = 0; n < 2; n++) begin
         u_crb_engine_model.send(29'h400, 1'b0, 1'b0, 1'b0, n, t);
         chk({31'h0, t}, {31'h0, n == 0}, "no overflow");
      end
      #1;
      chk({31'h0, full1}, 32'h0, "buffer 1 idle");
      $display("test double buffer done");
      // All-zero mask must let any valid identifier through
      for (int k = 6; k < 9; k++) begin
         fv[k] = 8'h00;
         wr(8'h04 + 8'(4 * k), fv[k]);
      end
      wr(8'h00, 8'h00);
      seed = lfsr(seed);
      u_crb_engine_model.send(seed[28:0], seed[29], 1'b0, 1'b0, 1, t);
      x = expect_msg(2'h0, seed[28:0], seed[29], 1'b0);
      chk({31'h0, t}, {31'h0, x[1]}, "zero mask");
      $display("test zero mask done");
      print_verdict();
   end
endmodule
